/* File: dsf_disk_pins.sv */
// Disk-side pin logic of the sector formatter: gates, serial data, marks, index.
// Assumes the sequencer drives requests on sys_clk; drive pins are asynchronous.
module dsf_disk_pins (
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       arst_n,
  // Sequencer control
  input  wire logic                       hard_sector,
  input  wire logic                       read_req,
  input  wire logic                       write_req,
  input  wire logic                       mark_req,
  input  wire logic [7:0]                 control_store,
  output dsf_pkg::dsf_event_t             events,
  // Write data in from buffer side
  input  wire logic                       wr_valid,
  output logic                            wr_ready,
  input  wire logic [dsf_pkg::DATA_W-1:0] wr_data,
  // Read data out to buffer side
  output logic                            rd_valid,
  input  wire logic                       rd_ready,
  output logic      [dsf_pkg::DATA_W-1:0] rd_data,
  output logic                            rd_overrun,
  // Drive pins
  input  wire logic                       disk_ref_clock,
  input  wire logic                       index_in,
  input  wire logic                       seq_sync_in,
  output logic                            seq_sync_out,
  output logic                            read_gate,
  output logic                            write_gate,
  input  wire logic                       nrz_in,
  output logic                            nrz_out,
  output logic                            nrz_oe,
  input  wire logic                       mark_found_in,
  output logic                            write_mark_strobe,
  output logic                            mark_oe
);
  localparam int SYN = 5;
  logic [SYN-1:0] s1_r;
  logic [SYN-1:0] s2_r;
  logic [SYN-1:0] s3_r;
  logic [SYN-1:0] in_now;

  dsf_pkg::dsf_state_t            state_r;
  logic [2:0]                     bit_cnt_r;
  logic [dsf_pkg::DATA_W-1:0]     sh_r;
  logic [dsf_pkg::DATA_W-1:0]     wsh_r;
  logic                           wsh_full_r;
  logic                           rx_push_r;
  logic                           rx_ready;
  logic [2:0]                     pulse_r;
  logic                           mark_armed_r;
  logic                           ref_rise;
  logic                           ref_fall;

  // Edge finders on a synchronised pin: newest stage and the one behind it
  function automatic logic rise_of(input logic cur_v, input logic old_v);
    return cur_v && !old_v;
  endfunction

  function automatic logic fall_of(input logic cur_v, input logic old_v);
    return !cur_v && old_v;
  endfunction

  assign in_now = {disk_ref_clock, index_in, seq_sync_in, mark_found_in, nrz_in};

  // Two-stage synchronisers, plus a third stage for edge finding
  // Stages reset to each pin's idle level, so release makes no false edge
  genvar g;
  generate
    for (g = 0; g < SYN; g++) begin : g_sync
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          s1_r[g] <= dsf_pkg::SYNC_RST[g];
          s2_r[g] <= dsf_pkg::SYNC_RST[g];
          s3_r[g] <= dsf_pkg::SYNC_RST[g];
        end else begin
          s1_r[g] <= in_now[g];
          s2_r[g] <= s1_r[g];
          s3_r[g] <= s2_r[g];
        end
      end
    end
  endgenerate

  // Serial bits move on the drive's reference clock edges
  assign ref_rise = rise_of(s2_r[4], s3_r[4]);
  assign ref_fall = fall_of(s2_r[4], s3_r[4]);

  // Gate state: read and write are exclusive, read has priority
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= dsf_pkg::DSF_IDLE;
    end else begin
      unique case (state_r)
        dsf_pkg::DSF_IDLE: begin
          if (read_req) begin
            state_r <= dsf_pkg::DSF_READ;
          end else if (write_req) begin
            state_r <= dsf_pkg::DSF_WRITE;
          end
        end
        dsf_pkg::DSF_READ: begin
          if (!read_req) begin
            state_r <= dsf_pkg::DSF_IDLE;
          end
        end
        dsf_pkg::DSF_WRITE: begin
          if (!write_req) begin
            state_r <= dsf_pkg::DSF_IDLE;
          end
        end
        default: state_r <= dsf_pkg::DSF_IDLE;
      endcase
    end
  end

  assign read_gate  = (state_r == dsf_pkg::DSF_READ);
  assign write_gate = (state_r == dsf_pkg::DSF_WRITE);
  assign nrz_oe     = write_gate;

  // Read path: shift in on rising reference edge, push each whole byte
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_cnt_r  <= dsf_pkg::BIT_CNT_RST;
      sh_r       <= '0;
      rx_push_r  <= 1'b0;
      rd_overrun <= 1'b0;
    end else begin
      rx_push_r <= 1'b0;
      if (state_r == dsf_pkg::DSF_IDLE) begin
        bit_cnt_r <= dsf_pkg::BIT_CNT_RST;
      end else if (read_gate && ref_rise) begin
        sh_r      <= {sh_r[dsf_pkg::DATA_W-2:0], s2_r[0]};
        bit_cnt_r <= 3'(bit_cnt_r + 1'b1);
        if (bit_cnt_r == 3'h7) begin
          rx_push_r <= 1'b1;
        end
      end else if (write_gate && ref_fall) begin
        bit_cnt_r <= 3'(bit_cnt_r + 1'b1);
      end
      if (rx_push_r && !rx_ready) begin
        rd_overrun <= 1'b1;
      end else if (read_req && !read_gate) begin
        rd_overrun <= 1'b0;
      end
    end
  end

  dsf_fifo #(
    .WIDTH (dsf_pkg::DATA_W),
    .DEPTH (dsf_pkg::FIFO_DEPTH)
  ) u_rx_fifo (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .flush     (1'b0),
    .in_valid  (rx_push_r),
    .in_ready  (rx_ready),
    .in_data   (sh_r),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data)
  );

  // Write path: load a byte whenever the shifter is empty, present bits MSB first on falling edge
  // No load on a shift edge, so no bit slot of the frame is skipped
  assign wr_ready = write_gate && !wsh_full_r && !ref_fall;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wsh_r      <= '0;
      wsh_full_r <= 1'b0;
      nrz_out    <= 1'b0;
    end else if (!write_gate) begin
      wsh_full_r <= 1'b0;
      nrz_out    <= 1'b0;
    end else begin
      if (wr_valid && wr_ready) begin
        wsh_r      <= wr_data;
        wsh_full_r <= 1'b1;
      end else if (ref_fall) begin
        nrz_out <= wsh_full_r ? wsh_r[dsf_pkg::DATA_W-1] : 1'b0;
        wsh_r   <= {wsh_r[dsf_pkg::DATA_W-2:0], 1'b0};
        if (bit_cnt_r == 3'h7) begin
          wsh_full_r <= 1'b0;
        end
      end
    end
  end

  // Mark strobe: fixed-length low pulse, soft sectors only
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pulse_r      <= '0;
      mark_armed_r <= 1'b1;
    end else begin
      if (!hard_sector && write_gate && mark_req && mark_armed_r) begin
        pulse_r      <= dsf_pkg::MARK_PULSE_N;
        mark_armed_r <= 1'b0;
      end else if (pulse_r != '0) begin
        pulse_r <= 3'(pulse_r - 1'b1);
      end
      if (!mark_req) begin
        mark_armed_r <= 1'b1;
      end
    end
  end

  assign mark_oe           = (pulse_r != '0) && !hard_sector;
  assign write_mark_strobe = !mark_oe;
  assign seq_sync_out      = control_store[dsf_pkg::CTL_OUT_BIT];

  // Drive-side events as one-cycle pulses
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      events <= '0;
    end else begin
      events.index_seen  <= rise_of(s2_r[3], s3_r[3]);
      events.seq_sync    <= rise_of(s2_r[2], s3_r[2]);
      events.sector_seen <= hard_sector && fall_of(s2_r[1], s3_r[1]);
      events.mark_found  <= !hard_sector && read_gate && fall_of(s2_r[1], s3_r[1]);
    end
  end
endmodule

/* File: dsf_pkg.sv */
// Package for the disk-side pin logic of the sector formatter.
// Assumes one system clock domain; the disk reference clock is sampled as data.
// Functional notes
// - Soft-sector mode with read gate: low on mark pin means mark found.
// - Hard-sector mode: mark pin is an input carrying the drive's sector pulse.
// - Read gate is asserted while a disk read takes serial data in.
// - Write gate enables serial write data out to the drive.
// - Serial pin is input under read gate, output under write gate.
// - Serial data is timed by the drive-supplied reference clock, not system clock.
// - Sequencer output pin follows bit 2 of current control-store control field.
// - Sequencer accepts an external input line to synchronise to outside events.
// - Index pulse from the drive is accepted on its own input, once per revolution.
package dsf_pkg;
  localparam int          DATA_W       = 8;
  localparam int          FIFO_DEPTH   = 16;
  localparam int          CTL_OUT_BIT  = 2;
  localparam int          MARK_PULSE_T = 4;
  localparam logic [2:0]  MARK_PULSE_N = 3'h4;
  localparam logic [2:0]  BIT_CNT_RST  = 3'h0;
  localparam logic [4:0]  SYNC_RST     = 5'h02;

  typedef enum logic [1:0] {
    DSF_IDLE,
    DSF_READ,
    DSF_WRITE
  } dsf_state_t;

  // Events seen on the drive side, one-cycle pulses
  typedef struct packed {
    logic index_seen;
    logic sector_seen;
    logic mark_found;
    logic seq_sync;
  } dsf_event_t;
endpackage

/* File: dsf_fifo.sv */
// Synchronous FIFO with valid/ready on both sides.
// Assumes both sides on sys_clk.
module dsf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             arst_n,
  input  wire logic             flush,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rp_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else if (flush) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= AW'(wp_r + 1'b1);
      end
      if (pop) begin
        rp_r <= AW'(rp_r + 1'b1);
      end
      cnt_r <= (AW+1)'(cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    end
  end
endmodule

/* File: dsf_disk_pins_asserts.sv */
// Checker for the disk-side pins of the sector formatter.
// Bound to dsf_disk_pins; sees only its ports, all on sys_clk.
module dsf_disk_pins_asserts (
  // Clock, reset and sequencer
  input wire logic                sys_clk,
  input wire logic                arst_n,
  input wire logic                hard_sector,
  input wire logic                read_req,
  input wire logic                write_req,
  input wire logic [7:0]          control_store,
  input wire dsf_pkg::dsf_event_t events,
  // Drive pins
  input wire logic                index_in,
  input wire logic                seq_sync_out,
  input wire logic                read_gate,
  input wire logic                write_gate,
  input wire logic                nrz_oe,
  input wire logic                mark_found_in,
  input wire logic                write_mark_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);
  chk_gate_excl: assert property (!(read_gate && write_gate)) else $error("both gates on");
  chk_oe_wgate: assert property (nrz_oe == write_gate) else $error("nrz enable wrong");
  chk_sync_out: assert property (seq_sync_out == control_store[2]) else $error("sync out wrong");
  chk_read_start: assert property (!read_gate && !write_gate && read_req |=> read_gate)
    else $error("read gate late");
  chk_write_start: assert property (!read_gate && !write_gate && write_req && !read_req |=> write_gate)
    else $error("write gate late");
  chk_read_hold: assert property (read_gate && read_req |=> read_gate) else $error("read gate dropped");
  chk_mark_len: assert property ($fell(write_mark_strobe) |-> !write_mark_strobe[*4] ##1 write_mark_strobe)
    else $error("mark strobe length");
  chk_mark_cause: assert property ($fell(write_mark_strobe) |-> $past(write_gate) && !hard_sector)
    else $error("mark strobe unasked");
  chk_index_evt: assert property ($rose(index_in) |-> ##[1:4] events.index_seen)
    else $error("index missed");
  chk_found_evt: assert property ($fell(mark_found_in) && read_gate && !hard_sector
    |-> ##[1:4] events.mark_found) else $error("mark missed");
  chk_sector_evt: assert property ($fell(mark_found_in) && hard_sector |-> ##[1:4] events.sector_seen)
    else $error("sector missed");
  cover property (read_gate ##1 !read_gate);
  cover property ($fell(write_mark_strobe));
  cover property (events.sector_seen);
endmodule

bind dsf_disk_pins dsf_disk_pins_asserts chk_i (.sys_clk(sys_clk), .arst_n(arst_n), .hard_sector(hard_sector),
  .read_req(read_req), .write_req(write_req), .control_store(control_store), .events(events),
  .index_in(index_in), .seq_sync_out(seq_sync_out), .read_gate(read_gate), .write_gate(write_gate),
  .nrz_oe(nrz_oe), .mark_found_in(mark_found_in), .write_mark_strobe(write_mark_strobe));

/* File: dsf_drive_model.sv */
// Drive-side model: reference clock only within gates, serial data, mark pin.
// Assumes the bench feeds it the formatter's gate and pin outputs.
module dsf_drive_model (
  // From formatter
  input wire logic       read_gate,
  input wire logic       write_gate,
  input wire logic       nrz_out,
  input wire logic       nrz_oe,
  input wire logic       write_mark_strobe,
  input wire logic       mark_oe,
  // From bench
  input wire logic       mark_cmd,
  input wire logic [7:0] wexp,
  // To formatter and bench
  output logic           disk_ref_clock,
  output logic           nrz_in,
  output logic           mark_found_in,
  output logic           hit,
  output logic [3:0]     marks
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] RD_PAT = 8'hA5;
  logic [7:0] wsh;
  logic       drv;
  int         bi;
  assign nrz_in = nrz_oe ? nrz_out : drv;
  // Mark pin has a pull-up; low while the drive signals a mark or sector
  assign mark_found_in = mark_oe ? write_mark_strobe : !mark_cmd;
  initial begin
    disk_ref_clock = 0;
    drv = 0;
    hit = 0;
    marks = 0;
    wsh = 0;
    bi = 7;
    forever begin
      if (read_gate || write_gate) begin
        drv = RD_PAT[bi];
        bi = (bi == 0) ? 7 : bi - 1;
        #32 disk_ref_clock = 1;
        #32 disk_ref_clock = 0;
      end else begin
        bi = 7;
        drv = ~drv;
        #4;
      end
    end
  end
  always @(posedge disk_ref_clock) if (write_gate) wsh <= {wsh[6:0], nrz_in};
  always @(wsh) if (wsh === wexp) hit = 1;
  always @(negedge write_mark_strobe) marks = marks + 4'h1;
endmodule

/* File: dsf_disk_pins_tb.sv */
// Self-checking bench for dsf_disk_pins with the drive model.
// Assumes a 250 MHz sys_clk and a 64 ns drive reference clock.
module dsf_disk_pins_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, arst_n, hard_sector, read_req, write_req, mark_req, wr_valid, wr_ready, rd_valid, rd_ready;
  logic rd_overrun, disk_ref_clock, index_in, seq_sync_in, seq_sync_out, read_gate, write_gate, nrz_in;
  logic nrz_out, nrz_oe, mark_found_in, write_mark_strobe, mark_oe, mark_cmd, hit, ev_clr;
  logic [7:0] control_store, wr_data, rd_data;
  logic [3:0] marks, ev_s;
  dsf_pkg::dsf_event_t events;
  int miscompares, compares;
  dsf_disk_pins dut (.sys_clk(sys_clk), .arst_n(arst_n), .hard_sector(hard_sector), .read_req(read_req),
    .write_req(write_req), .mark_req(mark_req), .control_store(control_store), .events(events),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .rd_data(rd_data), .rd_overrun(rd_overrun), .disk_ref_clock(disk_ref_clock), .index_in(index_in),
    .seq_sync_in(seq_sync_in), .seq_sync_out(seq_sync_out), .read_gate(read_gate), .write_gate(write_gate),
    .nrz_in(nrz_in), .nrz_out(nrz_out), .nrz_oe(nrz_oe), .mark_found_in(mark_found_in),
    .write_mark_strobe(write_mark_strobe), .mark_oe(mark_oe));
  dsf_drive_model drv (.read_gate(read_gate), .write_gate(write_gate), .nrz_out(nrz_out), .nrz_oe(nrz_oe),
    .write_mark_strobe(write_mark_strobe), .mark_oe(mark_oe), .mark_cmd(mark_cmd), .wexp(8'hA1),
    .disk_ref_clock(disk_ref_clock), .nrz_in(nrz_in), .mark_found_in(mark_found_in), .hit(hit), .marks(marks));
  // Sticky copy of the one-cycle event pulses
  always @(posedge sys_clk) ev_s <= ev_clr ? 4'h0 : ev_s | events;
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic t_read;
    int n;
    rd_ready <= 0;
    read_req <= 1;
    ev_clr <= 1;
    cyc(2);
    ev_clr <= 0;
    chk("read_gate", 1, read_gate);
    write_req <= 1;
    cyc(20);
    chk("write_gate", 0, write_gate);
    write_req <= 0;
    mark_cmd <= 1;
    cyc(4);
    mark_cmd <= 0;
    cyc(8);
    chk("mark_found", 1, ev_s[1]);
    cyc(18 * 128);
    chk("overrun", 1, rd_overrun);
    chk("rd_data", 8'hA5, rd_data);
    read_req <= 0;
    cyc(4);
    chk("read_gate", 0, read_gate);
    rd_ready <= 1;
    n = 0;
    repeat (40) begin
      @(posedge sys_clk);
      if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
        n++;
        chk("rd_byte", 8'hA5, rd_data);
      end
    end
    chk("rd_count", 8'h10, n[7:0]);
  endtask
  task automatic t_write;
    write_req <= 1;
    mark_req <= 1;
    cyc(2);
    chk("write_gate", 1, write_gate);
    wr_valid <= 1;
    wr_data <= 8'hA1;
    for (int i = 0; i < 2000; i++) begin
      @(posedge sys_clk);
      if (wr_ready === 1'b1) break;
    end
    wr_valid <= 0;
    cyc(400);
    chk("wr_byte", 1, hit);
    chk("marks", 1, marks);
    write_req <= 0;
    mark_req <= 0;
    cyc(4);
  endtask
  task automatic t_hard;
    hard_sector <= 1;
    ev_clr <= 1;
    cyc(1);
    ev_clr <= 0;
    mark_cmd <= 1;
    index_in <= 1;
    seq_sync_in <= 1;
    cyc(4);
    mark_cmd <= 0;
    index_in <= 0;
    seq_sync_in <= 0;
    cyc(8);
    chk("events", 8'h0D, ev_s);
    for (int i = 0; i < 8; i++) begin
      control_store <= 8'hFB ^ (8'h01 << i);
      cyc(1);
      chk("seq_out", (i == dsf_pkg::CTL_OUT_BIT) ? 8'h01 : 8'h00, seq_sync_out);
    end
  endtask
  task automatic end_sim;
    $display("miscompares %0d compares %0d", miscompares, compares);
    if (miscompares == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    sys_clk = 0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    end_sim;
  end
  initial begin
    {arst_n, hard_sector, read_req, write_req, mark_req, wr_valid, rd_ready, index_in} = 0;
    {seq_sync_in, mark_cmd, ev_clr, control_store, wr_data} = 0;
    cyc(12);
    arst_n <= 1;
    cyc(2);
    t_read;
    t_write;
    t_hard;
    end_sim;
  end
endmodule
